// >>> dbp_consts.svh
// constants for the two-wire debug port register access
`ifndef DBP_CONSTS_SVH
`define DBP_CONSTS_SVH

//----------------------------------------
// target register selector codes
//----------------------------------------
`define DBP_SEL_PART       8'h00
`define DBP_SEL_REV        8'h01
`define DBP_SEL_UNLOCK     8'h02
`define DBP_SEL_PDAT       8'hB4
`define DBP_READ_NONE      8'h00

//----------------------------------------
// unlock keys and flash command codes
//----------------------------------------
`define DBP_UNLOCK_KEY1    8'h02
`define DBP_UNLOCK_KEY2    8'h01
`define DBP_CMD_ERASE_ALL  8'h03
`define DBP_CMD_BLK_READ   8'h06
`define DBP_CMD_BLK_WRITE  8'h07
`define DBP_CMD_PAGE_ERASE 8'h08

// identity values, arbitrary
`define DBP_PART_CODE      8'h5A
`define DBP_SILICON_REV    8'h0C

//----------------------------------------
// link framing counts
//----------------------------------------
`define DBP_OP_LAST        3'h1
`define DBP_BYTE_LAST      3'h7
`define DBP_CK_HALF_LAST   3'h2
`define DBP_RD_FIRST       4'h4
`define DBP_WR_LAST        4'hA
`define DBP_RD_LAST        4'hB
`define DBP_WR_DRIVE       4'hB
`define DBP_RD_DRIVE       4'h3
`define DBP_SEQ_STEPS      2'h2

`endif

// >>> dbp_pkg.sv
// types shared by both ends of the debug port
`include "dbp_consts.svh"
package dbp_pkg;

	// link operation, bit 0 set means read
	typedef enum logic [1:0] {
		OP_SEL_WR = 2'b00,
		OP_SEL_RD = 2'b01,
		OP_DAT_WR = 2'b10,
		OP_DAT_RD = 2'b11
	} dbp_op_type;

	typedef enum logic [2:0] {
		LS_IDLE  = 3'b000,
		LS_OP    = 3'b001,
		LS_WDATA = 3'b010,
		LS_TURN  = 3'b011,
		LS_RDATA = 3'b100
	} dbp_lstate_type;

	typedef enum logic [1:0] {
		HS_IDLE = 2'b00,
		HS_LOW  = 2'b01,
		HS_HIGH = 2'b10
	} dbp_hstate_type;

	// device state on the link clock
	typedef struct packed {
		dbp_lstate_type st;
		logic [2:0]     cnt;
		logic [1:0]     op;
		logic [7:0]     sr;
		logic [7:0]     sel;
		logic [7:0]     unlock;
		logic           armed;
		logic           prog_en;
		logic [7:0]     pdat;
		logic           fcmd;
		logic           ftog;
		logic           d_o;
		logic           d_oe;
	} dbp_link_type;

	// device state on the system clock
	typedef struct packed {
		logic       tog_seen;
		logic       stb;
		logic [7:0] fbyte;
		logic       is_cmd;
		logic       prog_en;
		logic       user_rst;
		logic       pin_in;
	} dbp_sys_type;

	// host state
	typedef struct packed {
		dbp_hstate_type st;
		logic [2:0]     tmr;
		logic [3:0]     e;
		logic           rd;
		logic [10:0]    tx;
		logic [7:0]     rx;
		logic           ck;
		logic           d_o;
		logic           d_oe;
		logic           ready;
		logic           rsp_v;
		logic [7:0]     rsp_d;
		logic [7:0]     sel;
		logic [1:0]     seq;
		logic           trst;
	} dbp_host_type;

endpackage

// >>> dbp_link_if.sv
// two-wire debug link between host and device
interface dbp_link_if;
	logic ck;
	logic host_d_o;
	logic host_d_oe;
	logic dev_d_o;
	logic dev_d_oe;
	logic d;

	// resolved data line, pulled low when undriven
	assign d = host_d_oe ? host_d_o : (dev_d_oe ? dev_d_o : 1'h0);

	modport host (output ck, output host_d_o, output host_d_oe, input d);
	modport dev  (input ck, output dev_d_o, output dev_d_oe, input d);
endinterface

// >>> dbp_sync.sv
// two-flop synchroniser for levels entering a clock domain
module dbp_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output wire logic [W-1:0] q
);
	logic [1:0][W-1:0] stg_r;
	logic [1:0][W-1:0] stg_nxt;

	// first stage feeds only the second
	always_comb begin
		stg_nxt = {stg_r[0], d};
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stg_r <= '0;
		end else begin
			stg_r <= stg_nxt;
		end
	end

	assign q = stg_r[1];
endmodule

// >>> dbp_device.sv
// device end of the debug port: link framing and port registers
`include "dbp_consts.svh"
module dbp_device
	import dbp_pkg::*;
#(
	parameter logic [7:0] PART_CODE   = `DBP_PART_CODE,
	parameter logic [7:0] SILICON_REV = `DBP_SILICON_REV
) (
	input  wire logic       CLK,
	input  wire logic       RESET,
	input  wire logic       HALTED,
	output wire logic       PROG_ENABLED,
	output wire logic       FLASH_STB,
	output wire logic [7:0] FLASH_BYTE,
	output wire logic       FLASH_IS_CMD,
	output wire logic       USER_RESET,
	output wire logic       USER_PIN_IN,
	dbp_link_if.dev         LNK
);

	//----------------------------------------
	// helper functions
	//----------------------------------------

	// flash command codes the data register flags as commands
	function automatic logic is_flash_cmd(input logic [7:0] b);
		is_flash_cmd = (b == `DBP_CMD_ERASE_ALL) ||
			(b == `DBP_CMD_BLK_READ) ||
			(b == `DBP_CMD_BLK_WRITE) ||
			(b == `DBP_CMD_PAGE_ERASE);
	endfunction

	// value returned by a data read of the selected target
	function automatic logic [7:0] target_read(
		input logic [7:0] sel,
		input logic [7:0] unlock,
		input logic [7:0] pdat
	);
		case (sel)
		`DBP_SEL_PART: begin
			target_read = PART_CODE;
		end
		`DBP_SEL_REV: begin
			target_read = SILICON_REV;
		end
		`DBP_SEL_UNLOCK: begin
			target_read = unlock;
		end
		`DBP_SEL_PDAT: begin
			target_read = pdat;
		end
		default: begin
			target_read = `DBP_READ_NONE;
		end
		endcase
	endfunction

	//----------------------------------------
	// declarations
	//----------------------------------------
	dbp_link_type lr_r;
	dbp_link_type lr_nxt;
	dbp_sys_type  sy_r;
	dbp_sys_type  sy_nxt;
	logic         halted_lk;
	logic [3:0]   sys_s;
	logic [7:0]   wbyte;
	logic [7:0]   rbyte;

	//----------------------------------------
	// crossings
	//----------------------------------------

	// halt level into the link domain
	dbp_sync #(.W(1)) u_halt_sync (
		.clk (LNK.ck),
		.rst (RESET),
		.d   (HALTED),
		.q   (halted_lk)
	);

	// toggle, enable and both shared pins into the system domain
	dbp_sync #(.W(4)) u_sys_sync (
		.clk (CLK),
		.rst (RESET),
		.d   ({lr_r.ftog, lr_r.prog_en, LNK.ck, LNK.d}),
		.q   (sys_s)
	);

	//----------------------------------------
	// link domain: frame decoder and registers
	//----------------------------------------

	// next state of the link side, one bit per link clock edge
	always_comb begin
		lr_nxt = lr_r;
		wbyte  = {lr_r.sr[6:0], LNK.d};
		rbyte  = lr_r.op[1] ? target_read(lr_r.sel, lr_r.unlock, lr_r.pdat) : lr_r.sel;
		case (lr_r.st)
		LS_IDLE: begin
			// a high data bit opens a frame
			if (LNK.d) begin
				lr_nxt.st  = LS_OP;
				lr_nxt.cnt = '0;
			end
		end
		LS_OP: begin
			lr_nxt.op  = {lr_r.op[0], LNK.d};
			lr_nxt.cnt = lr_r.cnt + 3'h1;
			if (lr_r.cnt == `DBP_OP_LAST) begin
				lr_nxt.cnt = '0;
				lr_nxt.st  = LNK.d ? LS_TURN : LS_WDATA;
			end
		end
		LS_WDATA: begin
			lr_nxt.sr  = wbyte;
			lr_nxt.cnt = lr_r.cnt + 3'h1;
			if (lr_r.cnt == `DBP_BYTE_LAST) begin
				lr_nxt.st = LS_IDLE;
				if (lr_r.op == OP_SEL_WR) begin
					lr_nxt.sel = wbyte;
				end else if (halted_lk) begin
					// data writes land on the selected target
					if (lr_r.sel == `DBP_SEL_UNLOCK) begin
						lr_nxt.unlock = wbyte;
						lr_nxt.armed  = (wbyte == `DBP_UNLOCK_KEY1);
						if (lr_r.armed && wbyte == `DBP_UNLOCK_KEY2) begin
							lr_nxt.prog_en = 1'h1;
						end
					end else if (lr_r.sel == `DBP_SEL_PDAT && lr_r.prog_en) begin
						lr_nxt.pdat = wbyte;
						lr_nxt.fcmd = is_flash_cmd(wbyte);
						lr_nxt.ftog = ~lr_r.ftog;
					end
				end
			end
		end
		LS_TURN: begin
			// host released the line, device takes it
			lr_nxt.d_oe = 1'h1;
			lr_nxt.d_o  = rbyte[7];
			lr_nxt.sr   = {rbyte[6:0], 1'h0};
			lr_nxt.cnt  = '0;
			lr_nxt.st   = LS_RDATA;
		end
		LS_RDATA: begin
			if (lr_r.cnt == `DBP_BYTE_LAST) begin
				lr_nxt.d_oe = 1'h0;
				lr_nxt.d_o  = 1'h0;
				lr_nxt.st   = LS_IDLE;
			end else begin
				lr_nxt.d_o = lr_r.sr[7];
				lr_nxt.sr  = {lr_r.sr[6:0], 1'h0};
				lr_nxt.cnt = lr_r.cnt + 3'h1;
			end
		end
		default: begin
			lr_nxt.st   = LS_IDLE;
			lr_nxt.d_oe = 1'h0;
		end
		endcase
	end

	// link registers; only the RESET input clears the enable
	always_ff @(posedge LNK.ck or posedge RESET) begin
		if (RESET) begin
			lr_r <= '0;
		end else begin
			lr_r <= lr_nxt;
		end
	end

	// data line drive toward the link
	assign LNK.dev_d_o  = lr_r.d_o;
	assign LNK.dev_d_oe = lr_r.d_oe;

	//----------------------------------------
	// system domain: flash bytes and shared pins
	//----------------------------------------

	// next state of the system side
	always_comb begin
		sy_nxt          = sy_r;
		sy_nxt.tog_seen = sys_s[3];
		sy_nxt.stb      = sys_s[3] ^ sy_r.tog_seen;
		// byte is stable long before the toggle arrives
		if (sys_s[3] ^ sy_r.tog_seen) begin
			sy_nxt.fbyte  = lr_r.pdat;
			sy_nxt.is_cmd = lr_r.fcmd;
		end
		sy_nxt.prog_en  = sys_s[2];
		// pin is a low-true reset unless borrowed as link clock
		sy_nxt.user_rst = ~sys_s[1] & ~HALTED;
		// port input seen by user logic, frozen while borrowed
		sy_nxt.pin_in   = HALTED ? sy_r.pin_in : sys_s[0];
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			sy_r <= '0;
		end else begin
			sy_r <= sy_nxt;
		end
	end

	// outputs straight from the system registers
	assign PROG_ENABLED = sy_r.prog_en;
	assign FLASH_STB    = sy_r.stb;
	assign FLASH_BYTE   = sy_r.fbyte;
	assign FLASH_IS_CMD = sy_r.is_cmd;
	assign USER_RESET   = sy_r.user_rst;
	assign USER_PIN_IN  = sy_r.pin_in;

endmodule

// >>> dbp_host.sv
// host end of the debug port: clock divider and frame sender
`include "dbp_consts.svh"
module dbp_host
	import dbp_pkg::*;
(
	input  wire logic       CLK,
	input  wire logic       RESET,
	input  wire logic       CMD_VALID,
	input  wire logic [1:0] CMD_OP,
	input  wire logic [7:0] CMD_DATA,
	input  wire logic       CMD_UNLOCK,
	input  wire logic       TARGET_RESET_REQ,
	output wire logic       CMD_READY,
	output wire logic       RSP_VALID,
	output wire logic [7:0] RSP_DATA,
	output wire logic [7:0] CUR_SELECT,
	output wire logic       TARGET_RESET,
	dbp_link_if.host        LNK
);
	dbp_host_type hr_r;
	dbp_host_type hr_nxt;
	logic         din_s;
	logic         go;
	logic [1:0]   op_s;
	logic [7:0]   dat_s;

	// data line back from the pin
	dbp_sync #(.W(1)) u_din_sync (
		.clk (CLK),
		.rst (RESET),
		.d   (LNK.d),
		.q   (din_s)
	);

	//----------------------------------------
	// frame engine
	//----------------------------------------
	always_comb begin
		hr_nxt       = hr_r;
		hr_nxt.rsp_v = 1'h0;
		hr_nxt.trst  = TARGET_RESET_REQ;
		go           = 1'h0;
		op_s         = CMD_OP;
		dat_s        = CMD_DATA;
		case (hr_r.st)
		HS_IDLE: begin
			// unlock runs select, key one, key two
			if (hr_r.seq != 2'h0) begin
				go         = 1'h1;
				op_s       = OP_DAT_WR;
				dat_s      = (hr_r.seq == `DBP_SEQ_STEPS) ? `DBP_UNLOCK_KEY1 : `DBP_UNLOCK_KEY2;
				hr_nxt.seq = hr_r.seq - 2'h1;
			end else if (CMD_VALID && hr_r.ready) begin
				go = 1'h1;
				if (CMD_UNLOCK) begin
					op_s       = OP_SEL_WR;
					dat_s      = `DBP_SEL_UNLOCK;
					hr_nxt.seq = `DBP_SEQ_STEPS;
				end
			end
			if (go) begin
				hr_nxt.st   = HS_LOW;
				hr_nxt.tmr  = '0;
				hr_nxt.e    = '0;
				hr_nxt.rd   = op_s[0];
				hr_nxt.tx   = {1'h1, op_s, dat_s};
				hr_nxt.d_o  = 1'h1;
				hr_nxt.d_oe = 1'h1;
				if (op_s == OP_SEL_WR) begin
					hr_nxt.sel = dat_s;
				end
			end
		end
		HS_LOW: begin
			hr_nxt.tmr = hr_r.tmr + 3'h1;
			if (hr_r.tmr == `DBP_CK_HALF_LAST) begin
				hr_nxt.tmr = '0;
				hr_nxt.ck  = 1'h1;
				hr_nxt.st  = HS_HIGH;
				if (hr_r.rd && hr_r.e >= `DBP_RD_FIRST) begin
					hr_nxt.rx = {hr_r.rx[6:0], din_s};
				end
			end
		end
		HS_HIGH: begin
			hr_nxt.tmr = hr_r.tmr + 3'h1;
			if (hr_r.tmr == `DBP_CK_HALF_LAST) begin
				hr_nxt.tmr = '0;
				hr_nxt.ck  = 1'h0;
				if (hr_r.e == (hr_r.rd ? `DBP_RD_LAST : `DBP_WR_LAST)) begin
					hr_nxt.st    = HS_IDLE;
					hr_nxt.d_oe  = 1'h0;
					hr_nxt.d_o   = 1'h0;
					hr_nxt.rsp_v = hr_r.rd;
					hr_nxt.rsp_d = hr_r.rd ? hr_r.rx : hr_r.rsp_d;
				end else begin
					hr_nxt.st   = HS_LOW;
					hr_nxt.e    = hr_r.e + 4'h1;
					hr_nxt.tx   = {hr_r.tx[9:0], 1'h0};
					hr_nxt.d_o  = hr_r.tx[9];
					hr_nxt.d_oe = (hr_r.e + 4'h1) < (hr_r.rd ? `DBP_RD_DRIVE : `DBP_WR_DRIVE);
				end
			end
		end
		default: begin
			hr_nxt.st = HS_IDLE;
		end
		endcase
		hr_nxt.ready = (hr_nxt.st == HS_IDLE) && (hr_nxt.seq == 2'h0);
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			hr_r <= '0;
		end else begin
			hr_r <= hr_nxt;
		end
	end

	// outputs straight from registers
	assign CMD_READY     = hr_r.ready;
	assign RSP_VALID     = hr_r.rsp_v;
	assign RSP_DATA      = hr_r.rsp_d;
	assign CUR_SELECT    = hr_r.sel;
	assign TARGET_RESET  = hr_r.trst;
	assign LNK.ck        = hr_r.ck;
	assign LNK.host_d_o  = hr_r.d_o;
	assign LNK.host_d_oe = hr_r.d_oe;
endmodule

// >>> dbp_asserts.sv
// link-level checker for the two-wire debug port
`include "dbp_consts.svh"
module dbp_asserts #(
	parameter logic [7:0] PART_CODE   = `DBP_PART_CODE,
	parameter logic [7:0] SILICON_REV = `DBP_SILICON_REV
) (
	input  wire logic ck,
	input  wire logic RESET,
	input  wire logic host_d_o,
	input  wire logic host_d_oe,
	input  wire logic dev_d_oe,
	input  wire logic d
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] pos_r;
	logic [1:0] op_r;
	logic [7:0] sr_r;
	logic [7:0] sel_r;
	wire  logic [7:0] byte_now = {sr_r[6:0], d};

	//----------------------------------------
	// frame tracking
	//----------------------------------------
	// edge position in frame, opcode, shifted bits, selector copy
	always_ff @(posedge ck or posedge RESET) begin
		if (RESET) begin
			pos_r <= 4'h0;
			op_r  <= 2'h0;
			sr_r  <= 8'h00;
			sel_r <= 8'h00;
		end else begin
			sr_r <= byte_now;
			if (pos_r == 4'h1) op_r[1] <= d;
			if (pos_r == 4'h2) op_r[0] <= d;
			if (pos_r == 4'hA && op_r == 2'h0) sel_r <= byte_now;
			if (pos_r == 4'h0) pos_r <= {3'h0, d};
			else if (pos_r == (op_r[0] ? 4'hB : 4'hA)) pos_r <= 4'h0;
			else pos_r <= pos_r + 4'h1;
		end
	end

	//----------------------------------------
	// properties
	//----------------------------------------
	default clocking cb @(posedge ck);
	endclocking
	default disable iff (RESET);

	property p_one_driver; !(host_d_oe && dev_d_oe); endproperty
	property p_line_host; host_d_oe |-> d == host_d_o; endproperty
	property p_idle_quiet; pos_r == 4'h0 |-> !dev_d_oe; endproperty
	property p_hdr_host; pos_r inside {4'h1, 4'h2} |-> host_d_oe && !dev_d_oe; endproperty
	property p_wr_body; pos_r > 4'h2 && !op_r[0] |-> host_d_oe && !dev_d_oe; endproperty
	property p_rd_turn;
		pos_r == 4'h3 && op_r[0] |-> !host_d_oe ##1 (dev_d_oe && !host_d_oe)[*8] ##1 !dev_d_oe;
	endproperty
	property p_sel_echo; pos_r == 4'hB && op_r == 2'h1 |-> byte_now == sel_r; endproperty
	property p_part; pos_r == 4'hB && op_r == 2'h3 && sel_r == 8'h00 |-> byte_now == PART_CODE; endproperty
	property p_rev; pos_r == 4'hB && op_r == 2'h3 && sel_r == 8'h01 |-> byte_now == SILICON_REV; endproperty
	property p_unmapped;
		pos_r == 4'hB && op_r == 2'h3 && !(sel_r inside {8'h00, 8'h01, 8'h02, 8'hB4}) |-> byte_now == 8'h00;
	endproperty

	a_one_driver: assert property (p_one_driver) else $error("both ends drive");
	a_line_host: assert property (p_line_host) else $error("line not showing host bit");
	a_idle_quiet: assert property (p_idle_quiet) else $error("device drives idle line");
	a_hdr_host: assert property (p_hdr_host) else $error("header not host driven");
	a_wr_body: assert property (p_wr_body) else $error("write body not host driven");
	a_rd_turn: assert property (p_rd_turn) else $error("read turnaround wrong");
	a_sel_echo: assert property (p_sel_echo) else $error("selector readback wrong");
	a_part: assert property (p_part) else $error("part code wrong");
	a_rev: assert property (p_rev) else $error("revision wrong");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

	c_sel_wr: cover property (pos_r == 4'hA && op_r == 2'h0);
	c_rd_part: cover property (pos_r == 4'hB && op_r == 2'h3 && sel_r == 8'h00);
	c_wr_pdat: cover property (pos_r == 4'hA && op_r == 2'h2 && sel_r == 8'hB4);
endmodule

// >>> debug_port_register_access_bench.sv
// self-checking bench joining host and device over the link
`include "dbp_consts.svh"
module debug_port_register_access_bench
	import dbp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic            clk, rst, halted, valid, unl, t_req;
	logic [1:0]      op;
	logic [7:0]      dat, got;
	wire  logic      ready, rsp_v, prog_en, stb, is_cmd, usr_rst, t_rst, dev_rst, usr_pin;
	wire  logic [7:0] rsp_d, cur_sel, fbyte;
	int              fails = 0, tests_run = 0, stb_n = 0;

	dbp_link_if lnk();
	assign dev_rst = rst | t_rst;

	dbp_host dbp_host_inst (.CLK(clk), .RESET(rst), .CMD_VALID(valid), .CMD_OP(op), .CMD_DATA(dat),
		.CMD_UNLOCK(unl), .TARGET_RESET_REQ(t_req), .CMD_READY(ready), .RSP_VALID(rsp_v),
		.RSP_DATA(rsp_d), .CUR_SELECT(cur_sel), .TARGET_RESET(t_rst), .LNK(lnk));
	dbp_device dbp_device_inst (.CLK(clk), .RESET(dev_rst), .HALTED(halted), .PROG_ENABLED(prog_en),
		.FLASH_STB(stb), .FLASH_BYTE(fbyte), .FLASH_IS_CMD(is_cmd), .USER_RESET(usr_rst),
		.USER_PIN_IN(usr_pin), .LNK(lnk));
	dbp_asserts dbp_asserts_inst (.ck(lnk.ck), .RESET(dev_rst), .host_d_o(lnk.host_d_o),
		.host_d_oe(lnk.host_d_oe), .dev_d_oe(lnk.dev_d_oe), .d(lnk.d));

	//----------------------------------------
	// clock, pulse counter, helpers
	//----------------------------------------
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// counts flash byte pulses
	always @(negedge clk) if (stb === 1'b1) stb_n++;

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic give_up();
		fails++;
		conclude();
	endtask

	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (ready !== 1'b1 && n < 600);
		if (n >= 600) give_up();
	endtask

	// frame end plus margin for the 3-4 cycle crossing
	task automatic quiet();
		wait_ready();
		repeat (10) @(negedge clk);
	endtask

	task automatic send(input dbp_op_type o, input logic [7:0] v, input logic u);
		wait_ready();
		@(posedge clk);
		valid <= 1'b1;
		op <= o;
		dat <= v;
		unl <= u;
		@(posedge clk);
		valid <= 1'b0;
	endtask

	task automatic rd(input dbp_op_type o);
		int n;
		n = 0;
		send(o, 8'h00, 1'b0);
		while (rsp_v !== 1'b1 && n < 200) begin
			@(negedge clk);
			n++;
		end
		if (n >= 200) give_up();
		else got = rsp_d;
	endtask

	//----------------------------------------
	// scenarios
	//----------------------------------------
	task automatic t_ids();
		send(OP_SEL_WR, `DBP_SEL_PART, 1'b0);
		rd(OP_DAT_RD);
		check(got, `DBP_PART_CODE);
		send(OP_DAT_WR, 8'hFF, 1'b0);
		rd(OP_DAT_RD);
		check(got, `DBP_PART_CODE);
		send(OP_SEL_WR, `DBP_SEL_REV, 1'b0);
		rd(OP_SEL_RD);
		check(got, `DBP_SEL_REV);
		check(cur_sel, `DBP_SEL_REV);
		send(OP_DAT_WR, 8'h00, 1'b0);
		rd(OP_DAT_RD);
		check(got, `DBP_SILICON_REV);
		send(OP_SEL_WR, 8'h55, 1'b0);
		rd(OP_DAT_RD);
		check(got, 8'h00);
	endtask

	task automatic t_unlock();
		logic [7:0] codes [5] = '{8'h03, 8'h06, 8'h07, 8'h08, 8'h40};
		int n0;
		n0 = stb_n;
		send(OP_SEL_WR, `DBP_SEL_UNLOCK, 1'b0);
		rd(OP_DAT_RD);
		check(got, 8'h00);
		send(OP_SEL_WR, `DBP_SEL_PDAT, 1'b0);
		send(OP_DAT_WR, `DBP_CMD_ERASE_ALL, 1'b0);
		send(OP_SEL_WR, `DBP_SEL_UNLOCK, 1'b0);
		send(OP_DAT_WR, 8'h01, 1'b0);
		send(OP_DAT_WR, 8'h02, 1'b0);
		send(OP_DAT_WR, 8'h03, 1'b0);
		send(OP_DAT_WR, 8'h01, 1'b0);
		rd(OP_DAT_RD);
		check(got, 8'h01);
		check({7'h0, prog_en}, 8'h00);
		check(8'(stb_n - n0), 8'h00);
		send(OP_SEL_WR, 8'h00, 1'b1);
		quiet();
		check({7'h0, prog_en}, 8'h01);
		send(OP_SEL_WR, `DBP_SEL_PDAT, 1'b0);
		for (int i = 0; i < 5; i++) begin
			n0 = stb_n;
			send(OP_DAT_WR, codes[i], 1'b0);
			quiet();
			check(8'(stb_n - n0), 8'h01);
			check(fbyte, codes[i]);
			check({7'h0, is_cmd}, 8'(i < 4));
		end
		rd(OP_DAT_RD);
		check(got, 8'h40);
	endtask

	task automatic t_halt();
		int n0;
		@(posedge clk);
		halted <= 1'b0;
		n0 = stb_n;
		send(OP_DAT_WR, `DBP_CMD_BLK_WRITE, 1'b0);
		quiet();
		check(8'(stb_n - n0), 8'h00);
		check({7'h0, usr_rst}, 8'h01);
		check({7'h0, prog_en}, 8'h01);
		// read header holds the line high; running user logic must see it
		send(OP_DAT_RD, 8'h00, 1'h0);
		repeat (8) @(negedge clk);
		check({7'h0, usr_pin}, 8'h01);
		@(posedge clk);
		halted <= 1'h1;
		quiet();
		check({7'h0, usr_rst}, 8'h00);
		// line is low again, but the halted view stays frozen
		check({7'h0, usr_pin}, 8'h01);
	endtask

	task automatic t_reset();
		@(posedge clk);
		t_req <= 1'b1;
		repeat (4) @(posedge clk);
		t_req <= 1'b0;
		quiet();
		check({7'h0, prog_en}, 8'h00);
		rd(OP_DAT_RD);
		check(got, `DBP_PART_CODE);
		send(OP_SEL_WR, `DBP_SEL_UNLOCK, 1'b0);
		rd(OP_DAT_RD);
		check(got, 8'h00);
		send(OP_DAT_WR, `DBP_UNLOCK_KEY1, 1'b0);
		send(OP_DAT_WR, `DBP_UNLOCK_KEY2, 1'b0);
		quiet();
		check({7'h0, prog_en}, 8'h01);
	endtask

	//----------------------------------------
	// main sequence
	//----------------------------------------
	initial begin
		rst = 1'h0;
		halted = 1'b1;
		valid = 1'b0;
		unl = 1'b0;
		t_req = 1'b0;
		op = 2'h0;
		dat = 8'h00;
		// raise reset on an edge so every async reset sees it rise
		@(posedge clk);
		rst <= 1'h1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_ids();
		t_unlock();
		t_halt();
		t_reset();
		conclude();
	end
endmodule
